// [sal_defines.svh]
// Purpose: shared constants of the subtract execution block
// Assumes: included by bare name, once per compilation unit
// Notes:   offsets are byte addresses on the register bus
`ifndef SAL_DEFINES_SVH
`define SAL_DEFINES_SVH

// ********************************************************
// register map
// ********************************************************
`define SAL_AW           16
`define SAL_OFF_ACC      16'h0000
`define SAL_OFF_STATUS   16'h0004
`define SAL_OFF_BANK     16'h0008
`define SAL_OFF_INDEX    16'h000C
`define SAL_OFF_CTRL     16'h0010
`define SAL_OFF_INSTR    16'h0014
`define SAL_OFF_STATE    16'h0018
`define SAL_MEM_SEL      2'h1
`define SAL_MEM_DEPTH    4096

// ********************************************************
// field positions and reset values
// ********************************************************
`define SAL_FLG_C        0
`define SAL_FLG_NB       1
`define SAL_FLG_Z        2
`define SAL_FLG_SR       3
`define SAL_FLG_N        4
`define SAL_RST_ACC      8'h00
`define SAL_RST_STATUS   5'h00
`define SAL_RST_BANK     4'h0
`define SAL_RST_INDEX    12'h000
`define SAL_RST_INSTR    16'h0000

// ********************************************************
// instruction encoding and addressing
// ********************************************************
`define SAL_PFX_FILE     4'h5
`define SAL_SEL_BORROW   2'h1
`define SAL_SEL_FILE     2'h3
`define SAL_OPC_LIT      8'h08
`define SAL_ACC_SPLIT    8'h60
`define SAL_ILO_MAX      8'h5F
`define SAL_TOP_BANK     4'hF
`define SAL_DST_FILE     1'b1

`endif

// [sal_pkg.sv]
// Purpose: types of the subtract execution block
// Assumes: sal_defines.svh sits in the include path
// Notes:   all module state except the data memory travels as one packed struct
`default_nettype none
`include "sal_defines.svh"
package sal_pkg;

  // ********************************************************
  // enumerations
  // ********************************************************
  typedef enum logic [4:0] {
    SAL_IDLE = 5'h01,
    SAL_Q1   = 5'h02,
    SAL_Q2   = 5'h04,
    SAL_Q3   = 5'h08,
    SAL_Q4   = 5'h10
  } sal_phase_e;

  typedef enum logic [1:0] {
    SAL_OP_NONE   = 2'h0,
    SAL_OP_BORROW = 2'h1,
    SAL_OP_LIT    = 2'h2,
    SAL_OP_FILE   = 2'h3
  } sal_op_e;

  // ********************************************************
  // structs
  // ********************************************************
  typedef struct packed {
    sal_phase_e  phase;
    sal_op_e     op;
    logic [7:0]  acc;
    logic [4:0]  status;
    logic [3:0]  bank;
    logic [11:0] index;
    logic        ext_en;
    logic [15:0] instr;
    logic        illegal;
    logic [11:0] addr;
    logic [7:0]  opnd;
    logic [7:0]  res;
    logic [4:0]  flg;
    logic [31:0] prdata;
    logic        rdy;
    logic        slverr;
  } sal_state_s;

  typedef struct packed {
    logic [7:0]  acc;
    logic [4:0]  status;
    logic        busy;
    logic        illegal;
  } sal_obs_s;

endpackage : sal_pkg
`default_nettype wire

// [sal_sub_alu.sv]
// Purpose: 8-bit subtractor with flag generation
// Assumes: cin is 1 for a plain subtract, the carry flag for borrow
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "sal_defines.svh"
module sal_sub_alu (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       cin,
  output logic      [7:0] diff,
  output logic      [4:0] flags
);
  import sal_pkg::*;

  logic [8:0] full;
  logic [4:0] low;

  // carry out of a + ~b + cin is the inverted borrow
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, cin};
    low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, cin};
    diff = full[7:0];
    flags = 5'h00;
    flags[`SAL_FLG_C]  = full[8];
    flags[`SAL_FLG_NB] = low[4];
    flags[`SAL_FLG_Z]  = (full[7:0] == 8'h00);
    flags[`SAL_FLG_SR] = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
    flags[`SAL_FLG_N]  = full[7];
  end

endmodule : sal_sub_alu
`default_nettype wire

// [sal_addr_map.sv]
// Purpose: file register address formation
// Assumes: 16 banks of 256 bytes, index base of 12 bits
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "sal_defines.svh"
module sal_addr_map (
  input  wire logic [7:0]  file_addr,
  input  wire logic        bank_mode,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  input  wire logic        ext_en,
  output logic      [11:0] full_addr
);
  import sal_pkg::*;

  always_comb begin
    if (bank_mode) begin
      full_addr = {bank_select_register, file_addr};
    end else if (ext_en && (file_addr <= `SAL_ILO_MAX)) begin
      full_addr = index_base + {4'h0, file_addr};
    end else if (file_addr < `SAL_ACC_SPLIT) begin
      full_addr = {4'h0, file_addr};
    end else begin
      full_addr = {`SAL_TOP_BANK, file_addr};
    end
  end

endmodule : sal_addr_map
`default_nettype wire

// [sal_core.sv]
// Purpose: APB-reached execution unit for three subtract instructions
// Assumes: single clock, APB master holds requests until pready
// Notes:   data memory is not reset; bus is stalled while executing
`timescale 1ns/10ps
`default_nettype none
`include "sal_defines.svh"
// Function
// - borrow form: acc minus file minus inverted carry
// - decode 0101 01da ffff ffff
// - d=0 writes acc, d=1 writes file
// - a=0 access bank, a=1 bank select
// - a=0, extended, f<=5Fh uses indexed offset
// - one word, four phases: decode read process write
// - literal form: literal minus acc into acc
// - 0101 11da: file minus acc to destination
// - update the five arithmetic flags only
// - carry set without borrow, clear on borrow
// - zero on zero result, negative from msb
module sal_core #(
  parameter int MEM_DEPTH = `SAL_MEM_DEPTH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`SAL_AW-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  output sal_pkg::sal_obs_s          obs
);
  import sal_pkg::*;

  // ********************************************************
  // decode helpers
  // ********************************************************
  function automatic sal_op_e op_decode(input logic [15:0] ins);
    sal_op_e o;
    o = SAL_OP_NONE;
    if (ins[15:8] == `SAL_OPC_LIT) begin
      o = SAL_OP_LIT;
    end else if (ins[15:12] == `SAL_PFX_FILE && ins[11:10] == `SAL_SEL_BORROW) begin
      o = SAL_OP_BORROW;
    end else if (ins[15:12] == `SAL_PFX_FILE && ins[11:10] == `SAL_SEL_FILE) begin
      o = SAL_OP_FILE;
    end
    return o;
  endfunction : op_decode

  function automatic logic reg_hit(input logic [`SAL_AW-1:0] a);
    logic h;
    h = (a == `SAL_OFF_ACC) || (a == `SAL_OFF_STATUS) || (a == `SAL_OFF_BANK) ||
        (a == `SAL_OFF_INDEX) || (a == `SAL_OFF_CTRL) || (a == `SAL_OFF_INSTR) ||
        (a == `SAL_OFF_STATE) || (a[15:14] == `SAL_MEM_SEL);
    return h;
  endfunction : reg_hit

  // ********************************************************
  // state and datapath
  // ********************************************************
  sal_state_s  st_r;
  sal_state_s  st_nxt;
  logic [7:0]  mem [0:MEM_DEPTH-1];
  logic [11:0] map_addr;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic        alu_cin;
  logic [7:0]  alu_diff;
  logic [4:0]  alu_flags;
  logic        busy;
  logic        acc_phase;
  logic        done;
  logic        mem_hit;
  logic [11:0] mem_idx;
  logic        mem_wr_bus;
  logic        mem_wr_core;
  logic        dst_file;

  assign busy      = (st_r.phase != SAL_IDLE);
  assign acc_phase = psel && penable;
  assign done      = acc_phase && st_r.rdy;
  assign mem_hit   = (paddr[15:14] == `SAL_MEM_SEL);
  assign mem_idx   = paddr[13:2];
  assign dst_file  = st_r.instr[9];

  sal_addr_map u_addr (
    .file_addr            (st_r.instr[7:0]),
    .bank_mode            (st_r.instr[8]),
    .bank_select_register (st_r.bank),
    .index_base           (st_r.index),
    .ext_en               (st_r.ext_en),
    .full_addr            (map_addr)
  );

  // borrow form swaps the operand roles of the other two
  always_comb begin
    if (st_r.op == SAL_OP_BORROW) begin
      alu_a   = st_r.acc;
      alu_b   = st_r.opnd;
      alu_cin = st_r.status[`SAL_FLG_C];
    end else begin
      alu_a   = st_r.opnd;
      alu_b   = st_r.acc;
      alu_cin = 1'b1;
    end
  end

  sal_sub_alu u_alu (
    .minuend    (alu_a),
    .subtrahend (alu_b),
    .cin        (alu_cin),
    .diff       (alu_diff),
    .flags      (alu_flags)
  );

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_nxt = st_r;
    // bus answer: data is captured once the core is idle, so reads
    // never see a half executed instruction
    if (done) begin
      st_nxt.rdy    = 1'b0;
      st_nxt.slverr = 1'b0;
    end else if (psel && !st_r.rdy && !busy) begin
      st_nxt.rdy    = 1'b1;
      st_nxt.slverr = !reg_hit(paddr);
      st_nxt.prdata = 32'h0000_0000;
      if (mem_hit) begin
        st_nxt.prdata = {24'h00_0000, mem[mem_idx]};
      end else begin
        case (paddr)
          `SAL_OFF_ACC:    st_nxt.prdata = {24'h00_0000, st_r.acc};
          `SAL_OFF_STATUS: st_nxt.prdata = {27'h000_0000, st_r.status};
          `SAL_OFF_BANK:   st_nxt.prdata = {28'h000_0000, st_r.bank};
          `SAL_OFF_INDEX:  st_nxt.prdata = {20'h0_0000, st_r.index};
          `SAL_OFF_CTRL:   st_nxt.prdata = {31'h0000_0000, st_r.ext_en};
          `SAL_OFF_INSTR:  st_nxt.prdata = {16'h0000, st_r.instr};
          `SAL_OFF_STATE:  st_nxt.prdata = {30'h0000_0000, st_r.illegal, busy};
          default:         st_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (done && pwrite && !st_r.slverr) begin
      case (paddr)
        `SAL_OFF_ACC:    st_nxt.acc    = pwdata[7:0];
        `SAL_OFF_STATUS: st_nxt.status = pwdata[4:0];
        `SAL_OFF_BANK:   st_nxt.bank   = pwdata[3:0];
        `SAL_OFF_INDEX:  st_nxt.index  = pwdata[11:0];
        `SAL_OFF_CTRL:   st_nxt.ext_en = pwdata[0];
        `SAL_OFF_INSTR: begin
          st_nxt.instr = pwdata[15:0];
          st_nxt.phase = SAL_Q1;
        end
        default: st_nxt.ext_en = st_r.ext_en;
      endcase
    end
    case (st_r.phase)
      SAL_IDLE: begin
      end
      SAL_Q1: begin
        st_nxt.op      = op_decode(st_r.instr);
        st_nxt.addr    = map_addr;
        st_nxt.illegal = (op_decode(st_r.instr) == SAL_OP_NONE);
        st_nxt.phase   = (op_decode(st_r.instr) == SAL_OP_NONE) ? SAL_IDLE : SAL_Q2;
      end
      SAL_Q2: begin
        if (st_r.op == SAL_OP_LIT) begin
          st_nxt.opnd = st_r.instr[7:0];
        end else begin
          st_nxt.opnd = mem[st_r.addr];
        end
        st_nxt.phase = SAL_Q3;
      end
      SAL_Q3: begin
        st_nxt.res   = alu_diff;
        st_nxt.flg   = alu_flags;
        st_nxt.phase = SAL_Q4;
      end
      SAL_Q4: begin
        st_nxt.status = st_r.flg;
        if (st_r.op == SAL_OP_LIT || dst_file != `SAL_DST_FILE) begin
          st_nxt.acc = st_r.res;
        end
        st_nxt.phase = SAL_IDLE;
      end
      default: st_nxt.phase = SAL_IDLE;
    endcase
  end

  // ********************************************************
  // registers and memory
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.phase  <= SAL_IDLE;
      st_r.op     <= SAL_OP_NONE;
      st_r.acc    <= `SAL_RST_ACC;
      st_r.status <= `SAL_RST_STATUS;
      st_r.bank   <= `SAL_RST_BANK;
      st_r.index  <= `SAL_RST_INDEX;
      st_r.instr  <= `SAL_RST_INSTR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus writes are stalled while busy, so the two writers never meet
  assign mem_wr_bus  = done && pwrite && mem_hit;
  assign mem_wr_core = (st_r.phase == SAL_Q4) && (st_r.op != SAL_OP_LIT) &&
                       (dst_file == `SAL_DST_FILE);

  always_ff @(posedge pclk) begin
    if (mem_wr_core) begin
      mem[st_r.addr] <= st_r.res;
    end else if (mem_wr_bus) begin
      mem[mem_idx] <= pwdata[7:0];
    end
  end

  assign pready      = acc_phase && st_r.rdy;
  assign prdata      = st_r.prdata;
  assign pslverr     = acc_phase && st_r.rdy && st_r.slverr;
  assign obs         = '{acc:     st_r.acc,
                         status:  st_r.status,
                         busy:    busy,
                         illegal: st_r.illegal};

  // ********************************************************
  // assertions
  // ********************************************************
  a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q2) |=> (st_r.phase == SAL_Q3) ##1 (st_r.phase == SAL_Q4)
    ##1 (st_r.phase == SAL_IDLE))
    else $error("phases not in order");

  a_borrow_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && (st_r.instr[15:10] == 6'h15) |=> (st_r.op == SAL_OP_BORROW))
    else $error("borrow form not decoded");

  a_borrow_math: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_BORROW) |=>
    (st_r.res == 8'($past(st_r.acc) - $past(st_r.opnd) - 8'(!$past(st_r.status[0])))))
    else $error("borrow difference wrong");

  a_file_math: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_FILE) |=>
    (st_r.res == 8'($past(st_r.opnd) - $past(st_r.acc))))
    else $error("file difference wrong");

  a_lit_to_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q2) && (st_r.op == SAL_OP_LIT) |=> ##2
    (st_r.acc == 8'($past(st_r.instr[7:0], 3) - $past(st_r.acc, 3))))
    else $error("literal result not in acc");

  a_file_dest_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q4) && (st_r.op != SAL_OP_LIT) && dst_file |=> $stable(st_r.acc))
    else $error("acc changed for file destination");

  a_flags_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase != SAL_Q4) && !(done && pwrite && paddr == `SAL_OFF_STATUS)
    |=> $stable(st_r.status))
    else $error("status changed outside write phase");

  a_carry_lit: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_LIT) |=>
    (st_r.flg[`SAL_FLG_C] == ($past(st_r.opnd) >= $past(st_r.acc))))
    else $error("carry does not match borrow");

  a_zero_neg: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q4) |=> (st_r.status[`SAL_FLG_Z] == ($past(st_r.res) == 8'h00))
    && (st_r.status[`SAL_FLG_N] == $past(st_r.res[7])))
    else $error("zero or negative flag wrong");

  a_nibble_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_FILE) |=>
    (st_r.flg[`SAL_FLG_NB] == ($past(st_r.opnd[3:0]) >= $past(st_r.acc[3:0]))))
    else $error("nibble borrow flag wrong");

  a_bank_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && st_r.instr[8] |=>
    (st_r.addr == {$past(st_r.bank), $past(st_r.instr[7:0])}))
    else $error("bank address wrong");

  a_index_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && !st_r.instr[8] && st_r.ext_en && (st_r.instr[7:0] <= 8'h5F)
    |=> (st_r.addr == 12'($past(st_r.index) + $past(st_r.instr[7:0]))))
    else $error("indexed address wrong");

  // the flag checks below work from the operands, not from the adder, so a
  // fault in the adder cannot agree with itself; sign-extended difference
  logic [8:0]  ref_sdiff;
  assign ref_sdiff = {st_r.opnd[7], st_r.opnd} - {st_r.acc[7], st_r.acc};

  a_signed_range: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op != SAL_OP_BORROW) |=>
    (st_r.flg[`SAL_FLG_SR] == ($past(ref_sdiff[8]) != $past(ref_sdiff[7]))))
    else $error("signed range flag wrong");

  a_carry_file: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_FILE) |=>
    (st_r.flg[`SAL_FLG_C] == ($past(st_r.opnd) >= $past(st_r.acc))))
    else $error("file form carry wrong");

  // the inverted carry acts as the borrow in
  a_carry_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q3) && (st_r.op == SAL_OP_BORROW) |=>
    (st_r.flg[`SAL_FLG_C] == ({1'h0, $past(st_r.acc)} >=
     ({1'h0, $past(st_r.opnd)} + {8'h00, !$past(st_r.status[0])}))))
    else $error("borrow form carry wrong");

  a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q4) && (st_r.op != SAL_OP_LIT) && !dst_file
    |=> (st_r.acc == $past(st_r.res)))
    else $error("result not written to acc");

  // access bank split: with extended mode off, low bytes in page zero; the rest in the top page
  a_access_low: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && !st_r.instr[8] && !st_r.ext_en && (st_r.instr[7:0] < 8'h60)
    |=> (st_r.addr == {4'h0, $past(st_r.instr[7:0])}))
    else $error("low access bank address wrong");

  a_access_high: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && !st_r.instr[8] && (st_r.instr[7:0] >= 8'h60)
    |=> (st_r.addr == {4'hF, $past(st_r.instr[7:0])}))
    else $error("high access bank address wrong");

  // a read must never see a half executed instruction
  a_bus_stall: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> !pready)
    else $error("bus answered while executing");

  // the swapped borrow form is out of scope and must only raise illegal, leaving acc and status alone
  a_illegal_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.phase == SAL_Q1) && (st_r.instr[15:10] == 6'h16) |=>
    (st_r.phase == SAL_IDLE) && st_r.illegal && $stable(st_r.acc) && $stable(st_r.status))
    else $error("swapped borrow form not refused");

endmodule : sal_core
`default_nettype wire

// [subtract_instruction_alu_tb.sv]
// Purpose: self-checking bench for the subtract execution block
// Assumes: zero-wait APB while idle; the bus stalls while an instruction runs
// Notes:   flags {negative, range, zero, nibble, carry}; file bytes at 0x4000 + 4*i
`timescale 1ns/10ps
`default_nettype none
`include "sal_defines.svh"
module subtract_instruction_alu_tb;
  import sal_pkg::*;

  typedef struct packed {
    logic [15:0] instr;
    logic [7:0]  acc;
    logic        cin;
    logic [3:0]  bank;
    logic        ext;
    logic [11:0] maddr;
    logic [7:0]  mval;
    logic [7:0]  res;
    logic [4:0]  flg;
    logic        to_file;
  } sal_case_s;

  // ********************************************************
  // instruction table: code, acc, C, bank, ext, addr, byte, result, flags, dest
  // ********************************************************
  localparam sal_case_s CASES [12] = '{
    '{16'h5620, 8'h02, 1'h1, 4'h0, 1'h0, 12'h020, 8'h03, 8'hFF, 5'h10, 1'h1},
    '{16'h5421, 8'h05, 1'h1, 4'h0, 1'h0, 12'h021, 8'h02, 8'h03, 5'h03, 1'h0},
    '{16'h5740, 8'h02, 1'h0, 4'h2, 1'h0, 12'h240, 8'h01, 8'h00, 5'h07, 1'h1},
    '{16'h0802, 8'h01, 1'h0, 4'h0, 1'h0, 12'h030, 8'h55, 8'h01, 5'h03, 1'h0},
    '{16'h0802, 8'h02, 1'h1, 4'h0, 1'h0, 12'h030, 8'h55, 8'h00, 5'h07, 1'h0},
    '{16'h0802, 8'h03, 1'h0, 4'h0, 1'h0, 12'h030, 8'h55, 8'hFF, 5'h10, 1'h0},
    '{16'h5E5F, 8'h02, 1'h0, 4'h0, 1'h1, 12'h182, 8'h03, 8'h01, 5'h03, 1'h1},
    '{16'h5C60, 8'h02, 1'h0, 4'h0, 1'h1, 12'hF60, 8'h02, 8'h00, 5'h07, 1'h0},
    '{16'h5E10, 8'h02, 1'h0, 4'h0, 1'h0, 12'h010, 8'h01, 8'hFF, 5'h10, 1'h1},
    '{16'h5DFF, 8'h01, 1'h1, 4'hF, 1'h0, 12'hFFF, 8'h80, 8'h7F, 5'h09, 1'h0},
    '{16'h545F, 8'h7F, 1'h1, 4'h0, 1'h1, 12'h182, 8'hFF, 8'h80, 5'h1A, 1'h0},
    '{16'h5700, 8'h00, 1'h0, 4'hA, 1'h0, 12'hA00, 8'h00, 8'hFF, 5'h10, 1'h1}
  };

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  sal_obs_s    obs;
  int          bad_count;
  int          checks;

  always #12.5 pclk = ~pclk;

  sal_core #(
    .MEM_DEPTH(`SAL_MEM_DEPTH)
  ) dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .obs     (obs)
  );

  // ********************************************************
  // bus and checking tasks
  // ********************************************************
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk

  // request held from setup until pready is sampled high at a rising edge
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      $display("BAD pready expected 1 seen %b", pready);
      bad_count++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    xfer(1'h1, a, d, rd, e);
    chk("write_err", 32'h0, {31'h0, e});
  endtask : wr

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    xfer(1'h0, a, 32'h0, d, e);
    chk(nm, exp, d);
    chk({nm, "_err"}, 32'h0, {31'h0, e});
  endtask : rd_chk

  // counts the cycles the core stays busy after the launching edge
  task automatic exec(input logic [15:0] ins, input int cyc);
    int n;
    n = 0;
    wr(`SAL_OFF_INSTR, {16'h0, ins});
    #1;
    while (obs.busy === 1'h1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("busy_cycles", cyc, n);
    if (n >= 20) begin
      give_verdict();
    end
  endtask : exec

  task automatic run(input sal_case_s c);
    logic [15:0] ma;
    ma = 16'h4000 + {2'h0, c.maddr, 2'h0};
    wr(`SAL_OFF_ACC, {24'h0, c.acc});
    // stale flags above carry all set, carry from the case, so every one must be rewritten
    wr(`SAL_OFF_STATUS, {27'h0, 4'hF, c.cin});
    wr(`SAL_OFF_BANK, {28'h0, c.bank});
    wr(`SAL_OFF_CTRL, {31'h0, c.ext});
    wr(ma, {24'h0, c.mval});
    exec(c.instr, 4);
    rd_chk("acc", `SAL_OFF_ACC, {24'h0, c.to_file ? c.acc : c.res});
    rd_chk("file", ma, {24'h0, c.to_file ? c.res : c.mval});
    rd_chk("status", `SAL_OFF_STATUS, {27'h0, c.flg});
    rd_chk("state", `SAL_OFF_STATE, 32'h0);
    chk("obs_acc", {24'h0, c.to_file ? c.acc : c.res}, {24'h0, obs.acc});
    chk("obs_status", {27'h0, c.flg}, {27'h0, obs.status});
  endtask : run

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    logic [31:0] d;
    logic        e;
    logic [31:0] masks [5] = '{32'hFF, 32'h1F, 32'hF, 32'hFFF, 32'h1};
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset_value", 16'(4 * i), 32'h0);
    end
    // only the documented low bits may store
    for (int i = 0; i < 5; i++) begin
      wr(16'(4 * i), 32'hFFFFFFFF);
      rd_chk("reg_width", 16'(4 * i), masks[i]);
    end
    xfer(1'h0, 16'h0020, 32'h0, d, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, d);
    wr(`SAL_OFF_INDEX, 32'h123);
    wr(`SAL_OFF_ACC, 32'h5A);
    exec(16'h5820, 1);
    chk("obs_illegal", 32'h1, {31'h0, obs.illegal});
    rd_chk("state_illegal", `SAL_OFF_STATE, 32'h2);
    rd_chk("acc_kept", `SAL_OFF_ACC, 32'h5A);
    for (int i = 0; i < 12; i++) begin
      run(CASES[i]);
    end
    // a read issued while the core runs must wait for the final result
    wr(`SAL_OFF_ACC, 32'h3);
    wr(`SAL_OFF_INSTR, 32'h0810);
    rd_chk("stalled_read", `SAL_OFF_ACC, 32'h0D);
    chk("busy_done", 32'h0, {31'h0, obs.busy});
    give_verdict();
  end

endmodule : subtract_instruction_alu_tb
`default_nettype wire
